// ==== supervisor_pkg.sv ====
// Package for the speed limit supervisor: widths, delay defaults, modes, states, carriers.
// Assumes one 40 MHz clock; delays are given in ms and converted to clock cycles.
package supervisor_pkg;
   // ==========================================================================
   // Clock and timing
   localparam int          CLK_HZ                  = 40_000_000;
   localparam int          LIMIT_TIME_DELAY_MS     = 1000;
   localparam int          MODULATION_OFF_DELAY_MS = 200;
   localparam int          TIME_TO_ZERO_DELAY_MS   = 2000;
   localparam int          CYCLES_PER_MS           = CLK_HZ / 1000;
   localparam int          LIMIT_TIME_CYCLES       = LIMIT_TIME_DELAY_MS * CYCLES_PER_MS;
   localparam int          MOD_OFF_CYCLES          = MODULATION_OFF_DELAY_MS * CYCLES_PER_MS;
   localparam int          ZERO_SPEED_CYCLES       = TIME_TO_ZERO_DELAY_MS * CYCLES_PER_MS;
   localparam int          TIMER_W                 = 32;
   localparam int          SPEED_W                 = 16;
   localparam int          SET_COUNT               = 4;
   localparam int          SET_SEL_W               = 2;

   // ==========================================================================
   // Modulation loss reaction
   typedef enum logic [0:0] {
      REACT_MOD_OFF_DELAY = 1'b0,
      REACT_MONITORING    = 1'b1
   } modulation_loss_reaction_t;

   // ==========================================================================
   // Supervision states
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_RAMP    = 2'b01,
      ST_MONITOR = 2'b10,
      ST_STOPPED = 2'b11
   } sup_state_t;

   // ==========================================================================
   // Carriers
   typedef struct packed {
      logic [SPEED_W-1:0] speed_limit;
      logic [SPEED_W-1:0] trip_limit;
   } limits_t;

   typedef struct packed {
      logic                 emergency_stop_function;
      logic                 torque_off;
      logic [SET_COUNT-1:0] limit_indication;
   } outputs_t;
endpackage : supervisor_pkg

// ==== delay_timer.sv ====
// Loadable down-counting delay timer.
// Assumes start and stop are synchronous one-cycle or level requests.
`timescale 1ns/1ps
module delay_timer #(
   parameter int W = 32
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         start,
   input  wire logic         stop,
   input  wire logic [W-1:0] duration,
   output logic              running,
   output logic              expired
);
   logic [W-1:0] count_reg;

   // ==========================================================================
   // Counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= '0;
         running   <= 1'b0;
         expired   <= 1'b0;
      end else if (stop) begin
         running   <= 1'b0;
         expired   <= 1'b0;
      end else if (start) begin
         count_reg <= duration;
         running   <= 1'b1;
         expired   <= 1'b0;
      end else if (running) begin
         if (count_reg <= W'(1)) begin
            running <= 1'b0;
            expired <= 1'b1;
         end else begin
            count_reg <= count_reg - W'(1);
         end
      end
   end
endmodule : delay_timer

// ==== speed_limit_modloss_supervisor.sv ====
// Speed limit supervision during deceleration with modulation loss handling.
// Assumes all inputs synchronous to clk; speed is an unsigned magnitude.
// Functional notes
// - Request with speed above trip limit starts the limit time delay.
// - Modulation loss reaction selects off-delay mode or monitoring mode.
// - In off-delay mode modulation loss starts the modulation off delay.
// - Modulation returning within off delay avoids torque off; ramp continues.
// - Monitoring begins once speed falls below midway monitoring threshold.
// - Monitoring begins at the latest when the limit time delay expires.
// - Monitoring start asserts indication of the active one of four sets.
// - In monitoring mode loss freezes speed estimate and starts zero-speed delay.
// - Loss persisting and held speed above trip at delay expiry: emergency stop.
// - Emergency stop during modulation loss requests torque off directly.
// - Modulation back before expiry: drive decelerates; trip still checked at expiry.
// - In monitoring mode, lasting loss sets indication after zero-speed delay.
// - Off delay expiring without modulation activates torque off and indication.
`timescale 1ns/1ps
module speed_limit_modloss_supervisor #(
   parameter int LIMIT_TIME_CYCLES = supervisor_pkg::LIMIT_TIME_CYCLES,
   parameter int MOD_OFF_CYCLES    = supervisor_pkg::MOD_OFF_CYCLES,
   parameter int ZERO_SPEED_CYCLES = supervisor_pkg::ZERO_SPEED_CYCLES
) (
   input  wire logic                                     clk,
   input  wire logic                                     rst_n,
   input  wire logic                                     speed_limit_request,
   input  wire logic [supervisor_pkg::SET_SEL_W-1:0]     limit_set_select,
   input  wire supervisor_pkg::limits_t                  limits,
   input  wire logic [supervisor_pkg::SPEED_W-1:0]       motor_speed,
   input  wire logic                                     modulation_on,
   input  wire supervisor_pkg::modulation_loss_reaction_t modulation_loss_reaction,
   output logic                                          emergency_stop_function,
   output logic                                          torque_off,
   output logic                                          torque_off_indication,
   output logic                                          limit_indication_set1,
   output logic                                          limit_indication_set2,
   output logic                                          limit_indication_set3,
   output logic                                          limit_indication_set4,
   output logic                                          speed_estimate_frozen
);
   localparam int W = supervisor_pkg::TIMER_W;
   localparam int S = supervisor_pkg::SPEED_W;

   supervisor_pkg::sup_state_t state_reg;
   supervisor_pkg::outputs_t   out_reg;
   logic [S-1:0]               speed_est_reg;
   logic                       mod_on_d_reg;
   logic [S:0]                 threshold_sum;
   logic [S-1:0]               mon_threshold;
   logic                       request_start;
   logic                       mod_lost_evt;
   logic                       mod_back_evt;
   logic                       lt_exp;
   logic                       mo_exp;
   logic                       zs_exp;
   logic                       mo_run;
   logic                       zs_run;
   logic                       active;
   logic                       trip_now;
   logic                       begin_monitor;

   // ==========================================================================
   // Event decode
   assign active        = (state_reg == supervisor_pkg::ST_RAMP);
   assign request_start = speed_limit_request && (state_reg == supervisor_pkg::ST_IDLE)
                          && (motor_speed > limits.trip_limit);
   // Loss only counts in the ramp phase; later losses are left to the drive
   assign mod_lost_evt  = active && mod_on_d_reg && !modulation_on;
   assign mod_back_evt  = !mod_on_d_reg && modulation_on;
   // Midway threshold; extra bit keeps the sum from wrapping
   assign threshold_sum = {1'b0, limits.speed_limit} + {1'b0, limits.trip_limit};
   assign mon_threshold = threshold_sum[S:1];
   assign trip_now      = speed_est_reg > limits.trip_limit;
   // Speed relies on the drive ramping down on its own
   assign begin_monitor = active && (((speed_est_reg < mon_threshold) && !trip_now)
                          || (lt_exp && !trip_now));

   // ==========================================================================
   // Timers
   // Expired flags stay set until the request drops, the timer reloads or, for the off-delay and zero-speed timers, modulation returns
   delay_timer #(.W(W)) limit_timer (
      .clk      (clk),
      .rst_n    (rst_n),
      .start    (request_start),
      .stop     (!speed_limit_request),
      .duration (W'(LIMIT_TIME_CYCLES)),
      .running  (),
      .expired  (lt_exp)
   );

   delay_timer #(.W(W)) mod_off_timer (
      .clk      (clk),
      .rst_n    (rst_n),
      .start    (mod_lost_evt &&
                 modulation_loss_reaction == supervisor_pkg::REACT_MOD_OFF_DELAY),
      .stop     (mod_back_evt || !speed_limit_request),
      .duration (W'(MOD_OFF_CYCLES)),
      .running  (mo_run),
      .expired  (mo_exp)
   );

   delay_timer #(.W(W)) zero_speed_timer (
      .clk      (clk),
      .rst_n    (rst_n),
      .start    (mod_lost_evt),
      .stop     (mod_back_evt || !speed_limit_request),
      .duration (W'(ZERO_SPEED_CYCLES)),
      .running  (zs_run),
      .expired  (zs_exp)
   );

   // ==========================================================================
   // Modulation edge and speed estimate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mod_on_d_reg <= 1'b1;
      end else begin
         mod_on_d_reg <= modulation_on;
      end
   end

   // Frozen only in monitoring mode; off-delay mode keeps following the input
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         speed_est_reg         <= '0;
         speed_estimate_frozen <= 1'b0;
      end else if (modulation_on || !speed_limit_request) begin
         speed_est_reg         <= motor_speed;
         speed_estimate_frozen <= 1'b0;
      end else if (modulation_loss_reaction == supervisor_pkg::REACT_MONITORING
                   && active) begin
         speed_estimate_frozen <= 1'b1;
      end else if (!speed_estimate_frozen) begin
         speed_est_reg <= motor_speed;
      end
   end

   // ==========================================================================
   // Supervision state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= supervisor_pkg::ST_IDLE;
      end else if (!speed_limit_request) begin
         state_reg <= supervisor_pkg::ST_IDLE;
      end else begin
         case (state_reg)
            supervisor_pkg::ST_IDLE: begin
               if (request_start) begin
                  state_reg <= supervisor_pkg::ST_RAMP;
               end else begin
                  state_reg <= supervisor_pkg::ST_MONITOR;
               end
            end
            supervisor_pkg::ST_RAMP: begin
               if (lt_exp && trip_now) begin
                  state_reg <= supervisor_pkg::ST_STOPPED;
               end else if (mo_exp) begin
                  state_reg <= supervisor_pkg::ST_STOPPED;
               end else if (begin_monitor || zs_exp) begin
                  state_reg <= supervisor_pkg::ST_MONITOR;
               end
            end
            supervisor_pkg::ST_MONITOR: begin
               if (trip_now && modulation_on) begin
                  state_reg <= supervisor_pkg::ST_STOPPED;
               end
            end
            supervisor_pkg::ST_STOPPED: begin
               state_reg <= supervisor_pkg::ST_STOPPED;
            end
            default: begin
               state_reg <= supervisor_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================================
   // Outputs; held until the request drops, since stops are latched
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_reg               <= '0;
         torque_off_indication <= 1'b0;
      end else if (!speed_limit_request) begin
         out_reg               <= '0;
         torque_off_indication <= 1'b0;
      end else begin
         if (active && lt_exp && trip_now) begin
            // Trip check also applies once modulation has returned
            out_reg.emergency_stop_function <= 1'b1;
            if (!modulation_on) begin
               out_reg.torque_off    <= 1'b1;
               torque_off_indication <= 1'b1;
            end
         end
         if (state_reg == supervisor_pkg::ST_MONITOR && trip_now && modulation_on) begin
            out_reg.emergency_stop_function <= 1'b1;
         end
         if (active && mo_exp) begin
            out_reg.torque_off    <= 1'b1;
            torque_off_indication <= 1'b1;
         end
         if ((active && begin_monitor) || zs_exp) begin
            out_reg.limit_indication <= supervisor_pkg::SET_COUNT'(1) << limit_set_select;
         end
         if (state_reg == supervisor_pkg::ST_IDLE && !request_start) begin
            out_reg.limit_indication <= supervisor_pkg::SET_COUNT'(1) << limit_set_select;
         end
      end
   end

   assign emergency_stop_function = out_reg.emergency_stop_function;
   assign torque_off              = out_reg.torque_off;
   assign limit_indication_set1   = out_reg.limit_indication[0];
   assign limit_indication_set2   = out_reg.limit_indication[1];
   assign limit_indication_set3   = out_reg.limit_indication[2];
   assign limit_indication_set4   = out_reg.limit_indication[3];

   // Unused in this variant: running flags kept for visibility of timer status
   logic unused_run;
   assign unused_run = mo_run ^ zs_run;
endmodule : speed_limit_modloss_supervisor

// ==== supervisor_checker_assertions.sv ====
// Checker for the supervisor ports.
// Bound into each supervisor; one clock domain.
`timescale 1ns/1ps
module supervisor_checker #(
   parameter int LIMIT_TIME_CYCLES = 20,
   parameter int MOD_OFF_CYCLES    = 10,
   parameter int ZERO_SPEED_CYCLES = 40
) (
   input wire logic                                     clk,
   input wire logic                                     rst_n,
   input wire logic                                     speed_limit_request,
   input wire logic [supervisor_pkg::SET_SEL_W-1:0]     limit_set_select,
   input wire supervisor_pkg::limits_t                  limits,
   input wire logic [supervisor_pkg::SPEED_W-1:0]       motor_speed,
   input wire logic                                     modulation_on,
   input wire supervisor_pkg::modulation_loss_reaction_t modulation_loss_reaction,
   input wire logic                                     emergency_stop_function,
   input wire logic                                     torque_off,
   input wire logic                                     torque_off_indication,
   input wire logic                                     limit_indication_set1,
   input wire logic                                     limit_indication_set2,
   input wire logic                                     limit_indication_set3,
   input wire logic                                     limit_indication_set4,
   input wire logic                                     speed_estimate_frozen
);
   // ==========================================
   // Helper counters, saturating to stay small
   int         req_cnt_reg;
   int         off_cnt_reg;
   logic [3:0] ind;
   assign ind = {limit_indication_set4, limit_indication_set3,
                 limit_indication_set2, limit_indication_set1};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) req_cnt_reg <= 0;
      else if (!speed_limit_request) req_cnt_reg <= 0;
      else if (req_cnt_reg < 1000) req_cnt_reg <= req_cnt_reg + 1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) off_cnt_reg <= 0;
      else if (!speed_limit_request || modulation_on) off_cnt_reg <= 0;
      else if (off_cnt_reg < 1000) off_cnt_reg <= off_cnt_reg + 1;
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_dropped;
      speed_limit_request ##1 !speed_limit_request;
   endsequence
   sequence s_direct_trip;
      $rose(torque_off) && modulation_loss_reaction == supervisor_pkg::REACT_MONITORING;
   endsequence
   a_drop_clears: assert property (
      s_dropped |=> !emergency_stop_function && !torque_off && ind == 4'h0)
      else $error("outputs not cleared after request drop");
   a_ind_select: assert property (
      ind != 4'h0 |-> ind == (4'h1 << limit_set_select))
      else $error("indication not of the selected set");
   a_off_delay: assert property (
      $rose(torque_off) && modulation_loss_reaction == supervisor_pkg::REACT_MOD_OFF_DELAY
      |-> off_cnt_reg >= MOD_OFF_CYCLES)
      else $error("torque off before modulation off delay");
   a_direct_trip: assert property (
      s_direct_trip |-> emergency_stop_function && req_cnt_reg >= LIMIT_TIME_CYCLES)
      else $error("direct torque off without timed trip");
   a_tof_pair: assert property (
      torque_off_indication |-> torque_off)
      else $error("torque off indication without torque off");
   a_stop_latch: assert property (
      (emergency_stop_function || torque_off) && speed_limit_request
      |=> $stable(emergency_stop_function) && $stable(torque_off))
      else $error("stop outputs not latched");
   a_frozen_cause: assert property (
      $rose(speed_estimate_frozen) |-> $past(!modulation_on)
      && modulation_loss_reaction == supervisor_pkg::REACT_MONITORING)
      else $error("estimate frozen without loss in monitoring mode");
   a_mon_deadline: assert property (
      req_cnt_reg == LIMIT_TIME_CYCLES + 5 && !emergency_stop_function && !torque_off
      |-> ind != 4'h0)
      else $error("monitoring not started by limit delay expiry");
   a_zero_ind: assert property (
      off_cnt_reg == ZERO_SPEED_CYCLES + 4 && !emergency_stop_function
      && modulation_loss_reaction == supervisor_pkg::REACT_MONITORING |-> ind != 4'h0)
      else $error("no indication after zero speed delay");
endmodule : supervisor_checker
bind speed_limit_modloss_supervisor supervisor_checker #(
   .LIMIT_TIME_CYCLES(LIMIT_TIME_CYCLES), .MOD_OFF_CYCLES(MOD_OFF_CYCLES),
   .ZERO_SPEED_CYCLES(ZERO_SPEED_CYCLES)) u_chk (
   .clk(clk), .rst_n(rst_n), .speed_limit_request(speed_limit_request),
   .limit_set_select(limit_set_select), .limits(limits), .motor_speed(motor_speed),
   .modulation_on(modulation_on), .modulation_loss_reaction(modulation_loss_reaction),
   .emergency_stop_function(emergency_stop_function), .torque_off(torque_off),
   .torque_off_indication(torque_off_indication),
   .limit_indication_set1(limit_indication_set1), .limit_indication_set2(limit_indication_set2),
   .limit_indication_set3(limit_indication_set3), .limit_indication_set4(limit_indication_set4),
   .speed_estimate_frozen(speed_estimate_frozen));

// ==== drive_control_model.sv ====
// Drive control model: decel ramp, coasting, modulation.
// Assumes commands change at the falling edge.
`timescale 1ns/1ps
module drive_control_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        load,
   input  wire logic [15:0] load_speed,
   input  wire logic [15:0] decel_step,
   input  wire logic [15:0] target,
   input  wire logic        ramp_on,
   input  wire logic        kill,
   output logic [15:0]      motor_speed,
   output logic             modulation_on
);
   // ==========================================
   // Ramp and coast
   always_ff @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         motor_speed   <= 16'h0000;
         modulation_on <= 1'b1;
      end else begin
         modulation_on <= !kill;
         if (load) motor_speed <= load_speed;
         else if (modulation_on && ramp_on && motor_speed > target)
            motor_speed <= (motor_speed > target + decel_step) ? motor_speed - decel_step : target;
         else if (!modulation_on && motor_speed != 16'h0000) // Coast decays slowly
            motor_speed <= motor_speed - 16'h0001;
      end
   end
endmodule : drive_control_model

// ==== speed_limit_modloss_supervisor_tb_top.sv ====
// Testbench for the speed limit supervisor.
// Assumes the drive model and the bound checker.
`timescale 1ns/1ps
module speed_limit_modloss_supervisor_tb_top;
   logic                                      clk = 1'b0;
   logic                                      rst_n = 1'b0;
   logic                                      req = 1'b0;
   logic                                      load = 1'b0;
   logic                                      kill = 1'b0;
   logic [1:0]                                sel = 2'h0;
   logic [15:0]                               ld_spd = 16'h0000;
   logic [15:0]                               step = 16'h0000;
   logic [15:0]                               speed;
   logic                                      mod_on;
   logic                                      es, to, toi, fr, i1, i2, i3, i4;
   logic [7:0]                                outs;
   logic [31:0]                               rng = 32'h00000056;
   supervisor_pkg::limits_t                   lim = {16'h03E8, 16'h07D0};
   supervisor_pkg::modulation_loss_reaction_t mode = supervisor_pkg::REACT_MOD_OFF_DELAY;
   int                                        bad_count = 0;
   int                                        tests_run = 0;
   int                                        tn = 0;
   assign outs = {fr, es, to, toi, i4, i3, i2, i1};
   always #12.5 clk = ~clk;
   // ==========================================
   // Design and drive model
   speed_limit_modloss_supervisor #(.LIMIT_TIME_CYCLES(20), .MOD_OFF_CYCLES(10),
      .ZERO_SPEED_CYCLES(40)) dut (
      .clk(clk), .rst_n(rst_n), .speed_limit_request(req), .limit_set_select(sel),
      .limits(lim), .motor_speed(speed), .modulation_on(mod_on),
      .modulation_loss_reaction(mode), .emergency_stop_function(es), .torque_off(to),
      .torque_off_indication(toi), .limit_indication_set1(i1), .limit_indication_set2(i2),
      .limit_indication_set3(i3), .limit_indication_set4(i4), .speed_estimate_frozen(fr));
   drive_control_model drive (.clk(clk), .rst_n(rst_n), .load(load), .load_speed(ld_spd),
      .decel_step(step), .target(lim.speed_limit), .ramp_on(req), .kill(kill),
      .motor_speed(speed), .modulation_on(mod_on));
   // ==========================================
   // Helpers
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : xs
   function automatic logic [7:0] expect_outs(input logic [4:0] f, input logic [1:0] s);
      return {f[4:1], f[0] ? (4'h1 << s) : 4'h0};
   endfunction : expect_outs
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   // Flags {frozen, stop, torque off, its indication, set indication}
   task automatic scen(input logic md, input logic [15:0] spd, input logic [15:0] stp,
                       input int l0, input int l1, input int n,
                       input logic [4:0] f, input logic [7:0] m);
      logic [31:0] r;
      r = xs();
      @(negedge clk);
      req <= 1'b0;
      load <= 1'b1;
      ld_spd <= spd;
      step <= stp;
      kill <= 1'b0;
      mode <= supervisor_pkg::modulation_loss_reaction_t'(md);
      @(negedge clk);
      load <= 1'b0;
      @(negedge clk);
      chk(outs, 8'h00);
      sel <= r[1:0];
      req <= 1'b1;
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         kill <= (i >= l0 && i < l1);
      end
      chk(outs & m, expect_outs(f, r[1:0]) & m);
      tn++;
      $display("scenario %0d done", tn);
   endtask : scen
   // ==========================================
   // Sequence and watchdog
   initial begin
      logic [31:0] r;
      repeat (12) @(negedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk(outs, 8'h00);
      for (int k = 0; k < 4; k++) begin
         r = xs();
         scen(r[12], {6'h00, r[9:0]}, 16'h0000, 0, 0, 4, 5'h01, 8'hFF);
      end
      scen(1'b0, 16'h0BB8, 16'h0000, 2, 200, 18, 5'h06, 8'hF0);
      scen(1'b0, 16'h0BB8, 16'h0064, 2, 6, 30, 5'h01, 8'hFF);
      scen(1'b0, 16'h0BB8, 16'h0000, 2, 6, 30, 5'h08, 8'hE0);
      scen(1'b1, 16'h0BB8, 16'h0000, 2, 200, 30, 5'h1C, 8'hE0);
      scen(1'b1, 16'h0834, 16'h0032, 4, 200, 30, 5'h11, 8'hFF);
      scen(1'b1, 16'h0BB8, 16'h0000, 2, 200, 55, 5'h1F, 8'hFF);
      scen(1'b1, 16'h0BB8, 16'h0064, 2, 6, 30, 5'h01, 8'hFF);
      tally_and_finish();
   end
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
endmodule : speed_limit_modloss_supervisor_tb_top
